// file: fpuc_pkg.sv
// Purpose: Shared constants and types for the flash program unlock control block
// Assumes: 16-bit register write port from the processor, one clock
// Notes: Register offsets here are word offsets on the private register port
package fpuc_pkg;
    localparam logic [0:0] FPUC_ADDR_CTRL = 1'h0;
    localparam logic [0:0] FPUC_ADDR_KEY = 1'h1;
    localparam logic [7:0] FPUC_KEY_FIRST = 8'h55;
    localparam logic [7:0] FPUC_KEY_SECOND = 8'hAA;
    localparam int FPUC_START_BIT = 15;
    localparam int FPUC_TYPE_LSB = 0;
    localparam int FPUC_TYPE_W = 4;
    localparam int FPUC_BLOCK_LSB = 4;
    localparam int FPUC_BLOCK_W = 4;
    localparam logic [15:0] FPUC_CTRL_RESET = 16'h0000;
    localparam int FPUC_ROW_WORDS = 64;
    localparam int FPUC_ROW_BYTES = 192;
    localparam int FPUC_PAGE_BYTES = 1536;
    localparam logic [3:0] FPUC_OP_ROW = 4'h1;
    localparam logic [3:0] FPUC_OP_PAGE_ERASE = 4'h2;
    localparam logic [3:0] FPUC_OP_WORD = 4'h3;

    typedef struct packed {
        logic [3:0] block_sel;
        logic [3:0] mem_type;
    } fpuc_op_t;

    typedef struct packed {
        logic [23:0] addr;
        logic [23:0] data;
    } fpuc_word_t;

    typedef enum logic [1:0] {
        FPUC_KEY_IDLE = 2'b00,
        FPUC_KEY_HALF = 2'b01,
        FPUC_KEY_OPEN = 2'b11
    } fpuc_key_t;

    typedef enum logic [1:0] {
        FPUC_OP_IDLE = 2'b00,
        FPUC_OP_RUN = 2'b01,
        FPUC_OP_WAIT = 2'b11
    } fpuc_state_t;
endpackage

// file: fpuc_row_buf.sv
// Purpose: Row holding buffer for one flash row of instruction words
// Assumes: Single writer and single reader, same clock
// Notes: Read data come from a register one cycle after the address
`timescale 1ns/1ns
module fpuc_row_buf #(
    parameter int WORDS = 64,
    parameter int WIDTH = 24
) (
    input wire logic mclk_in,
    input wire logic wr_en_in,
    input wire logic [$clog2(WORDS)-1:0] wr_idx_in,
    input wire logic [WIDTH-1:0] wr_data_in,
    input wire logic [$clog2(WORDS)-1:0] rd_idx_in,
    output logic [WIDTH-1:0] rd_data_out
);
    logic [WIDTH-1:0] mem [WORDS];

    always_ff @(posedge mclk_in) begin
        if (wr_en_in) begin
            mem[wr_idx_in] <= wr_data_in;
        end
    end

    always_ff @(posedge mclk_in) begin
        rd_data_out <= mem[rd_idx_in];
    end
endmodule

// file: fpuc_ctrl.sv
// Purpose: Run-time self-programming control: unlock key, start/stop, row buffer load
// Assumes: Processor writes registers on a private 16-bit port; flash array is external
// Notes: Start is accepted only right after the two key writes; start bit self clears
`timescale 1ns/1ns
module fpuc_ctrl #(
    parameter int ROW_WORDS = fpuc_pkg::FPUC_ROW_WORDS,
    parameter int WORD_W = 24
) (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic reg_wr_in,
    input wire logic [0:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [15:0] reg_rdata_out,
    input wire logic buf_wr_in,
    input wire fpuc_pkg::fpuc_word_t buf_word_in,
    output logic buf_align_err_out,
    output logic cpu_stall_out,
    output logic flash_go_out,
    output fpuc_pkg::fpuc_op_t flash_op_out,
    output logic [23:0] flash_addr_out,
    output logic flash_wr_out,
    output fpuc_pkg::fpuc_word_t flash_word_out,
    input wire logic flash_done_in
);
    localparam int IDX_W = $clog2(ROW_WORDS);

    // Index wrap and the fixed 24-bit word struct pin both sizes
    if (ROW_WORDS != fpuc_pkg::FPUC_ROW_WORDS || WORD_W != 24) begin : g_cfg_check
        $error("fpuc_ctrl: unsupported row size or word width");
    end

    fpuc_pkg::fpuc_key_t key_r;
    fpuc_pkg::fpuc_state_t state_r;
    logic [15:0] ctrl_r;
    logic [IDX_W-1:0] load_idx_r;
    logic [23:0] row_base_r;
    logic [IDX_W-1:0] prog_idx_r;
    logic [IDX_W-1:0] word_idx_r;
    logic rd_valid_r;
    logic [WORD_W-1:0] buf_rdata;
    logic ctrl_wr;
    logic key_wr;
    logic start_req;
    logic start_ok;
    logic aligned_ok;
    logic [3:0] op_type;
    logic [3:0] run_type;

    assign ctrl_wr = reg_wr_in && reg_addr_in == fpuc_pkg::FPUC_ADDR_CTRL;
    assign key_wr = reg_wr_in && reg_addr_in == fpuc_pkg::FPUC_ADDR_KEY;
    assign start_req = ctrl_wr && reg_wdata_in[fpuc_pkg::FPUC_START_BIT];
    assign op_type = reg_wdata_in[fpuc_pkg::FPUC_TYPE_LSB +: fpuc_pkg::FPUC_TYPE_W];
    assign run_type = ctrl_r[fpuc_pkg::FPUC_TYPE_LSB +: fpuc_pkg::FPUC_TYPE_W];

    // Target address must sit on the boundary the operation works on
    always_comb begin
        unique case (op_type)
            fpuc_pkg::FPUC_OP_PAGE_ERASE:
                aligned_ok = (row_base_r % 24'(fpuc_pkg::FPUC_PAGE_BYTES)) == 24'h000000;
            fpuc_pkg::FPUC_OP_ROW:
                aligned_ok = (row_base_r % 24'(fpuc_pkg::FPUC_ROW_BYTES)) == 24'h000000;
            default:
                aligned_ok = 1'b1;
        endcase
    end

    assign start_ok = start_req && key_r == fpuc_pkg::FPUC_KEY_OPEN
        && state_r == fpuc_pkg::FPUC_OP_IDLE && aligned_ok;

    // Unlock sequence: any register write other than the expected key closes it
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            key_r <= fpuc_pkg::FPUC_KEY_IDLE;
        end else if (reg_wr_in) begin
            if (key_wr && reg_wdata_in[7:0] == fpuc_pkg::FPUC_KEY_FIRST) begin
                key_r <= fpuc_pkg::FPUC_KEY_HALF;
            end else if (key_wr && key_r == fpuc_pkg::FPUC_KEY_HALF
                    && reg_wdata_in[7:0] == fpuc_pkg::FPUC_KEY_SECOND) begin
                key_r <= fpuc_pkg::FPUC_KEY_OPEN;
            end else begin
                key_r <= fpuc_pkg::FPUC_KEY_IDLE;
            end
        end else if (buf_wr_in) begin
            key_r <= fpuc_pkg::FPUC_KEY_IDLE;
        end
    end

    // Control register: selection fields are writable only while idle
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            ctrl_r <= fpuc_pkg::FPUC_CTRL_RESET;
        end else if (state_r == fpuc_pkg::FPUC_OP_WAIT && flash_done_in) begin
            ctrl_r[fpuc_pkg::FPUC_START_BIT] <= 1'b0;
        end else if (ctrl_wr && state_r == fpuc_pkg::FPUC_OP_IDLE) begin
            ctrl_r[14:0] <= reg_wdata_in[14:0];
            ctrl_r[fpuc_pkg::FPUC_START_BIT] <= start_ok;
        end
    end

    // Row buffer load index: sequential words from an aligned group
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            load_idx_r <= '0;
            row_base_r <= 24'h000000;
            buf_align_err_out <= 1'b0;
        end else if (buf_wr_in && state_r == fpuc_pkg::FPUC_OP_IDLE) begin
            if (load_idx_r == '0) begin
                row_base_r <= buf_word_in.addr;
            end
            buf_align_err_out <= buf_word_in.addr[IDX_W-1:0] != load_idx_r;
            load_idx_r <= IDX_W'(load_idx_r + 1'b1);
        end else if (start_ok) begin
            load_idx_r <= '0;
        end
    end

    fpuc_row_buf #(
        .WORDS(ROW_WORDS),
        .WIDTH(WORD_W)
    ) u_row_buf (
        .mclk_in(mclk_in),
        .wr_en_in(buf_wr_in && state_r == fpuc_pkg::FPUC_OP_IDLE),
        .wr_idx_in(load_idx_r),
        .wr_data_in(buf_word_in.data),
        .rd_idx_in(prog_idx_r),
        .rd_data_out(buf_rdata)
    );

    // Operation sequencer: streams the row for a row program, then waits for the array to finish
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            state_r <= fpuc_pkg::FPUC_OP_IDLE;
            prog_idx_r <= '0;
            rd_valid_r <= 1'b0;
        end else begin
            rd_valid_r <= state_r == fpuc_pkg::FPUC_OP_RUN
                && run_type == fpuc_pkg::FPUC_OP_ROW;
            unique case (state_r)
                fpuc_pkg::FPUC_OP_IDLE: begin
                    prog_idx_r <= '0;
                    if (start_ok) begin
                        state_r <= fpuc_pkg::FPUC_OP_RUN;
                    end
                end
                fpuc_pkg::FPUC_OP_RUN: begin
                    if (run_type != fpuc_pkg::FPUC_OP_ROW
                            || prog_idx_r == IDX_W'(ROW_WORDS - 1)) begin
                        state_r <= fpuc_pkg::FPUC_OP_WAIT;
                    end else begin
                        prog_idx_r <= IDX_W'(prog_idx_r + 1'b1);
                    end
                end
                fpuc_pkg::FPUC_OP_WAIT: begin
                    if (flash_done_in) begin
                        state_r <= fpuc_pkg::FPUC_OP_IDLE;
                    end
                end
                default: state_r <= fpuc_pkg::FPUC_OP_IDLE;
            endcase
        end
    end

    // Buffer read data lag the read index by one cycle, so the address lags too
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            word_idx_r <= '0;
        end else begin
            word_idx_r <= prog_idx_r;
        end
    end

    // Flash side outputs
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            flash_go_out <= 1'b0;
            flash_op_out <= '0;
            flash_addr_out <= 24'h000000;
            flash_wr_out <= 1'b0;
            flash_word_out <= '0;
        end else begin
            flash_go_out <= start_ok;
            if (start_ok) begin
                flash_op_out.block_sel <= reg_wdata_in[fpuc_pkg::FPUC_BLOCK_LSB +:
                    fpuc_pkg::FPUC_BLOCK_W];
                flash_op_out.mem_type <= op_type;
                flash_addr_out <= row_base_r;
            end
            flash_wr_out <= rd_valid_r;
            flash_word_out.addr <= row_base_r + 24'(word_idx_r);
            flash_word_out.data <= buf_rdata;
        end
    end

    // Stall rises with go, the cycle after acceptance, and drops the cycle after the array reports done
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            cpu_stall_out <= 1'b0;
        end else begin
            cpu_stall_out <= start_ok || (state_r != fpuc_pkg::FPUC_OP_IDLE
                && !(state_r == fpuc_pkg::FPUC_OP_WAIT && flash_done_in));
        end
    end

    // Readback: key register reads as zero
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            reg_rdata_out <= reg_addr_in == fpuc_pkg::FPUC_ADDR_CTRL ? ctrl_r : 16'h0000;
        end
    end
endmodule

// file: fpuc_ctrl_properties.sv
// Purpose: Port assertions for the flash unlock control block
// Assumes: One clock, synchronous active-high reset
// Notes: Bound into fpuc_ctrl below
`timescale 1ns/1ns
module fpuc_ctrl_checker (
    input wire logic mclk_in,
    input wire logic srst_in,
    input wire logic reg_wr_in,
    input wire logic [0:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    input wire logic reg_rd_in,
    input wire logic [15:0] reg_rdata_out,
    input wire logic cpu_stall_out,
    input wire logic flash_go_out,
    input wire logic flash_wr_out,
    input wire logic flash_done_in
);
    default clocking @(posedge mclk_in); endclocking
    default disable iff (srst_in);
    go_from_start_a:
        assert property (flash_go_out |-> $past(reg_wr_in && !reg_addr_in && reg_wdata_in[15]))
        else $error("go without start write");
    go_stalls_a:
        assert property (flash_go_out |-> cpu_stall_out) else $error("go without stall");
    go_pulse_a:
        assert property (flash_go_out |=> !flash_go_out) else $error("go longer than a cycle");
    go_when_idle_a:
        assert property (flash_go_out |-> !$past(cpu_stall_out)) else $error("go while busy");
    stall_rise_a:
        assert property ($rose(cpu_stall_out) |-> flash_go_out) else $error("stall without go");
    stall_end_a:
        assert property ($fell(cpu_stall_out) |-> $past(flash_done_in)) else $error("early end");
    stream_busy_a:
        assert property (flash_wr_out |-> cpu_stall_out) else $error("stream while idle");
    key_reads_zero_a:
        assert property (reg_rd_in && reg_addr_in |=> reg_rdata_out == 16'h0000)
        else $error("key readable");
    cover property (flash_go_out);
    cover property ($fell(cpu_stall_out));
    cover property (flash_wr_out);
endmodule
bind fpuc_ctrl fpuc_ctrl_checker i_chk (.mclk_in(mclk_in), .srst_in(srst_in),
    .reg_wr_in(reg_wr_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .cpu_stall_out(cpu_stall_out),
    .flash_go_out(flash_go_out), .flash_wr_out(flash_wr_out), .flash_done_in(flash_done_in));

// file: test_flash_program_unlock_control.sv
// Purpose: Self-checking bench for the flash unlock control block
// Assumes: 125 MHz clock, reset held 12 cycles
// Notes: Random data from a fixed seed plus boundary cases
`timescale 1ns/1ns
module test_flash_program_unlock_control;
    logic mclk_in = 1'b0;
    logic srst_in = 1'b1;
    logic reg_wr_in = 1'b0;
    logic [0:0] reg_addr_in = 1'h0;
    logic [15:0] reg_wdata_in = 16'h0000;
    logic reg_rd_in = 1'b0;
    logic buf_wr_in = 1'b0;
    fpuc_pkg::fpuc_word_t buf_word_in = '0;
    logic flash_done_in = 1'b0;
    logic [15:0] reg_rdata_out;
    logic buf_align_err_out, cpu_stall_out, flash_go_out, flash_wr_out;
    fpuc_pkg::fpuc_op_t flash_op_out;
    logic [23:0] flash_addr_out;
    fpuc_pkg::fpuc_word_t flash_word_out;
    int mismatches = 0;
    int compares = 0;
    int seed = 32'hd5d7;
    logic [23:0] row_data [64];
    initial forever #4 mclk_in = ~mclk_in;
    fpuc_ctrl i_dut (.mclk_in(mclk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .buf_wr_in(buf_wr_in), .buf_word_in(buf_word_in),
        .buf_align_err_out(buf_align_err_out), .cpu_stall_out(cpu_stall_out),
        .flash_go_out(flash_go_out), .flash_op_out(flash_op_out),
        .flash_addr_out(flash_addr_out), .flash_wr_out(flash_wr_out),
        .flash_word_out(flash_word_out), .flash_done_in(flash_done_in));
    function automatic logic aligned(input logic [3:0] ty, input logic [23:0] base);
        if (ty == fpuc_pkg::FPUC_OP_ROW) return (base % fpuc_pkg::FPUC_ROW_BYTES) == 0;
        if (ty == fpuc_pkg::FPUC_OP_PAGE_ERASE) return (base % fpuc_pkg::FPUC_PAGE_BYTES) == 0;
        return 1'b1;
    endfunction
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [0:0] a, input logic [15:0] d);
        @(posedge mclk_in);
        reg_wr_in <= 1'b1;
        reg_addr_in <= a;
        reg_wdata_in <= d;
    endtask
    task automatic idle;
        @(posedge mclk_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        buf_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [0:0] a, input logic [15:0] exp);
        @(posedge mclk_in);
        reg_rd_in <= 1'b1;
        reg_addr_in <= a;
        idle;
        @(posedge mclk_in);
        #1 chk(reg_rdata_out, exp);
    endtask
    task automatic run_op(input logic [3:0] ty, input logic [3:0] blk, input logic [23:0] base,
                          input logic [7:0] k2);
        int n;
        int w;
        logic go;
        for (int i = 0; i < 64; i++) begin
            row_data[i] = 24'($random(seed));
            @(posedge mclk_in);
            buf_wr_in <= 1'b1;
            buf_word_in <= {base + 24'(i), row_data[i]};
        end
        idle;
        wr(1'h1, 16'h0055);
        wr(1'h1, {8'h00, k2});
        wr(1'h0, {8'h80, blk, ty});
        idle;
        go = 1'b0;
        for (n = 0; n < 4 && !go; n++) begin
            #1 go = (flash_go_out === 1'b1);
            if (!go) @(posedge mclk_in);
        end
        chk(buf_align_err_out, 1'b0);
        chk(go, k2 == 8'hAA && aligned(ty, base));
        if (go) begin
            chk({flash_op_out, flash_addr_out}, {blk, ty, base});
            w = 0;
            for (n = 0; n < 100; n++) begin
                @(posedge mclk_in);
                reg_wr_in <= (n == 5);
                reg_wdata_in <= 16'h00F3;
                #1 chk(cpu_stall_out, 1'b1);
                if (flash_wr_out === 1'b1) begin
                    chk(flash_word_out, {base + 24'(w), row_data[w[5:0]]});
                    w++;
                end
            end
            if (ty == fpuc_pkg::FPUC_OP_ROW) chk(48'(w), 48'h40);
            @(posedge mclk_in);
            flash_done_in <= 1'b1;
            @(posedge mclk_in);
            flash_done_in <= 1'b0;
            for (n = 0; n < 4 && cpu_stall_out !== 1'b0; n++) @(posedge mclk_in);
            chk(cpu_stall_out, 1'b0);
        end
        if (go || k2 != 8'hAA) rd(1'h0, {8'h00, blk, ty});
        $display("Operation type %h base %h finished", ty, base);
    endtask
    task automatic report_and_stop;
        $display("compares=%0d mismatches=%0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk_in);
        mismatches++;
        report_and_stop;
    end
    initial begin
        logic [15:0] d;
        repeat (12) @(posedge mclk_in);
        srst_in <= 1'b0;
        rd(1'h0, fpuc_pkg::FPUC_CTRL_RESET);
        for (int i = 0; i < 6; i++) begin
            d = 16'($random(seed)) & 16'h7FFF;
            wr(1'h0, d);
            idle;
            rd(1'h0, d);
        end
        wr(1'h1, 16'h0055);
        idle;
        rd(1'h1, 16'h0000);
        wr(1'h1, 16'h0055);
        wr(1'h0, 16'h0001);
        wr(1'h1, 16'h00AA);
        wr(1'h0, 16'h8001);
        idle;
        repeat (6) begin
            @(posedge mclk_in);
            #1 chk(flash_go_out, 1'b0);
        end
        $display("Register and interrupted unlock tests finished");
        for (int t = 1; t < 4; t++) begin
            run_op(4'(t), 4'($random(seed)), 24'(1536 * ($random(seed) & 15)), 8'hAA);
        end
        run_op(fpuc_pkg::FPUC_OP_ROW, 4'h5, 24'h0000C0, 8'hAA);
        run_op(fpuc_pkg::FPUC_OP_PAGE_ERASE, 4'h5, 24'h0000C0, 8'hAA);
        run_op(fpuc_pkg::FPUC_OP_ROW, 4'h3, 24'h000600, 8'h5A);
        @(posedge mclk_in);
        buf_wr_in <= 1'b1;
        buf_word_in <= {24'h000005, 24'h000000};
        idle;
        @(posedge mclk_in);
        #1 chk(buf_align_err_out, 1'b1);
        $display("Row alignment error test finished");
        report_and_stop;
    end
endmodule
